// ### core/timer_cfg_regs.svh
// Register addresses, field positions, masks and counts for the timer configuration block
`ifndef TIMER_CFG_REGS_SVH
`define TIMER_CFG_REGS_SVH

// Special-function register addresses
`define ADDR_MODE_CFG      8'h89
`define ADDR_PRESCALE      8'h8e
`define ADDR_T2_CTRL       8'hc8
`define ADDR_T2_LOW        8'hca
`define ADDR_T2_HIGH       8'hcb

// Reset values
`define MODE_CFG_RESET     8'h00
`define PRESCALE_RESET     8'h00
`define T2_CTRL_RESET      8'h00
`define T2_CNT_RESET       16'h0000

// Mode register, timer zero half
`define MODE_T0_GATE       3
`define MODE_T0_CSEL       2
`define MODE_T0_HI         1
`define MODE_T0_LO         0

// Clock prescale select fields; only bits 5..3 are writable
`define PRESCALE_T2_DIV    5
`define PRESCALE_T1_DIV    4
`define PRESCALE_T0_DIV    3
`define PRESCALE_WMASK     8'h38

// Timer two control fields; bits 7..6 are flags kept elsewhere
`define T2_CTRL_RX_BAUD    5
`define T2_CTRL_TX_BAUD    4
`define T2_CTRL_RUN        2
`define T2_CTRL_CSEL       1
`define T2_CTRL_CAP_SEL    0
`define T2_CTRL_WMASK      8'h3f

// Prescaler and timer two counter counts
`define DIV12_LAST      4'hb
`define DIV12_ZERO      4'h0
`define T2_CNT_MAX      16'hffff
`define T2_CNT_ONE      16'h0001

`endif

// ### core/timer_cfg_pkg.sv
// Types shared by the timer clock and mode select block
package timer_cfg_pkg;

    // Timer zero operating modes, in mode-field order
    typedef enum logic [1:0] {
        T0_MODE_13BIT,
        T0_MODE_16BIT,
        T0_MODE_8BIT_RELOAD,
        T0_MODE_SPLIT_8BIT
    } t0_mode_t;

    // Timer two operating modes
    typedef enum logic [2:0] {
        T2_OFF,
        T2_CAPTURE,
        T2_RELOAD,
        T2_BAUD_TX,
        T2_BAUD_RX,
        T2_BAUD_TXRX
    } t2_mode_t;

endpackage

// ### core/timer_clock_and_mode_select.sv
// Timer clock prescale, gating, mode decode and timer two counter
//
// Function
// RL1: Gate bit makes timer zero wait for pin
// RL2: Timer zero mode field selects four modes
// RL3: Counter select picks clock or pin falling edge
// RL4: Timer one clock is sysclk/12 or sysclk
// RL5: Timer two select bit gives undivided clock
// RL6: Low three prescale bits read zero
// RL7: Top two prescale bits unused, read zero
// RL8: Timer two is two separately written bytes
// RL9: Timer two timer mode uses sysclk/1 or /12
// RL10: Timer two counter mode counts pin falls
// RL11: Timer two overflow can trigger conversion
// RL12: Capture mode from control bits and run
// RL13: Auto-reload mode from control bits and run
// RL14: Baud select bits override capture/reload select
// RL15: Mode from control register, off without run
`timescale 1ns/1ps
`default_nettype none
`include "timer_cfg_regs.svh"

module timer_clock_and_mode_select (
    input  wire logic                    i_sys_clk,
    input  wire logic                    i_resetn,
    input  wire logic                    i_clk_en,
    input  wire logic [7:0]              i_sfr_addr,
    input  wire logic [7:0]              i_sfr_wdata,
    input  wire logic                    i_sfr_wr,
    input  wire logic                    i_sfr_rd,
    input  wire logic                    i_t0_run,
    input  wire logic                    i_ext_irq_zero_pin,
    input  wire logic                    i_t0_count_pin,
    input  wire logic                    i_t2_count_pin,
    output logic [7:0]                   o_sfr_rdata,
    output logic                         o_t0_count_en,
    output logic                         o_t0_tick,
    output var timer_cfg_pkg::t0_mode_t  o_t0_mode,
    output logic                         o_t1_tick,
    output var timer_cfg_pkg::t2_mode_t  o_t2_mode,
    output logic                         o_t2_overflow,
    output logic                         o_adc_trigger
);
    import timer_cfg_pkg::*;

    logic [7:0]  mode_q;
    logic [7:0]  presc_q;
    logic [7:0]  t2_ctl_q;
    logic [15:0] t2_cnt_q;
    logic [3:0]  div12_q;
    logic        half_q;
    logic [2:0]  irq0_sync_q;
    logic [2:0]  t0p_sync_q;
    logic [2:0]  t2p_sync_q;

    // Address decode
    wire sel_mode   = (i_sfr_addr == `ADDR_MODE_CFG);
    wire sel_presc  = (i_sfr_addr == `ADDR_PRESCALE);
    wire sel_t2_ctl = (i_sfr_addr == `ADDR_T2_CTRL);
    wire sel_t2_low = (i_sfr_addr == `ADDR_T2_LOW);
    wire sel_t2_hi  = (i_sfr_addr == `ADDR_T2_HIGH);
    wire wr_t2_low  = i_sfr_wr & sel_t2_low;
    wire wr_t2_hi   = i_sfr_wr & sel_t2_hi;

    // Shared prescaler taps
    wire div12_tick = (div12_q == `DIV12_LAST);
    wire half_tick  = half_q;

    // Synchronised pins; stage 0 feeds only stage 1
    wire irq0_level = irq0_sync_q[1];
    wire t0_fall    = t0p_sync_q[2] & ~t0p_sync_q[1];
    wire t2_fall    = t2p_sync_q[2] & ~t2p_sync_q[1];

    // Timer zero gating and clock choice
    wire t0_gate     = mode_q[`MODE_T0_GATE];
    wire t0_ct       = mode_q[`MODE_T0_CSEL];
    wire t0_enable   = i_t0_run & (~t0_gate | irq0_level);                  // RL1
    wire t0_timebase = presc_q[`PRESCALE_T0_DIV] ? 1'b1 : div12_tick;
    wire t0_tick_d   = t0_enable & (t0_ct ? t0_fall : t0_timebase);         // RL3
    wire [1:0] t0_mode_bits = {mode_q[`MODE_T0_HI], mode_q[`MODE_T0_LO]};
    wire t0_mode_t t0_mode_d = t0_mode_t'(t0_mode_bits);                    // RL2

    // Timer one timebase
    wire t1_tick_d = presc_q[`PRESCALE_T1_DIV] ? 1'b1 : div12_tick;         // RL4

    // Timer two mode decode
    wire t2_run          = t2_ctl_q[`T2_CTRL_RUN];
    wire rx_baud_src_sel = t2_ctl_q[`T2_CTRL_RX_BAUD];
    wire tx_baud_src_sel = t2_ctl_q[`T2_CTRL_TX_BAUD];
    wire t2_baud         = rx_baud_src_sel | tx_baud_src_sel;
    wire t2_ct           = t2_ctl_q[`T2_CTRL_CSEL];
    wire t2_mode_t t2_mode_d =
        !t2_run                              ? T2_OFF       :               // RL15
        (rx_baud_src_sel & tx_baud_src_sel)  ? T2_BAUD_TXRX :               // RL14
        rx_baud_src_sel                      ? T2_BAUD_RX   :
        tx_baud_src_sel                      ? T2_BAUD_TX   :
        t2_ctl_q[`T2_CTRL_CAP_SEL]           ? T2_CAPTURE   :               // RL12
                                               T2_RELOAD;                   // RL13

    // Baud mode fixes the timebase at sysclk/2; select bit ignored there
    wire t2_timebase = t2_baud ? half_tick
                     : (presc_q[`PRESCALE_T2_DIV] ? 1'b1 : div12_tick);     // RL5 RL9
    wire t2_inc  = t2_run & (t2_ct ? t2_fall : t2_timebase);                // RL10
    wire t2_wrap = t2_inc & (t2_cnt_q == `T2_CNT_MAX);

    // Byte-wise counter update; a byte write beats the increment
    wire [15:0] t2_cnt_inc = t2_cnt_q + `T2_CNT_ONE;
    wire [15:0] t2_cnt_d;
    assign t2_cnt_d[7:0]  = wr_t2_low ? i_sfr_wdata                         // RL8
                          : (t2_inc ? t2_cnt_inc[7:0] : t2_cnt_q[7:0]);
    assign t2_cnt_d[15:8] = wr_t2_hi ? i_sfr_wdata
                          : (t2_inc ? t2_cnt_inc[15:8] : t2_cnt_q[15:8]);

    // Read mux; unmapped addresses answer zero
    wire [7:0] rdata_d =
        sel_mode   ? mode_q :
        sel_presc  ? (presc_q & `PRESCALE_WMASK) :                          // RL6 RL7
        sel_t2_ctl ? (t2_ctl_q & `T2_CTRL_WMASK) :
        sel_t2_low ? t2_cnt_q[7:0] :
        sel_t2_hi  ? t2_cnt_q[15:8] : 8'h00;

    // Configuration registers; prescale masks drop reserved and unused bits
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            mode_q   <= `MODE_CFG_RESET;
            presc_q  <= `PRESCALE_RESET;
            t2_ctl_q <= `T2_CTRL_RESET;
        end else if (i_clk_en && i_sfr_wr) begin
            if (sel_mode)
                mode_q <= i_sfr_wdata;
            if (sel_presc)
                presc_q <= i_sfr_wdata & `PRESCALE_WMASK;                   // RL6 RL7
            if (sel_t2_ctl)
                t2_ctl_q <= i_sfr_wdata & `T2_CTRL_WMASK;                   // RL15
        end
    end

    // Prescaler and timer two count
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            div12_q  <= `DIV12_ZERO;
            half_q   <= 1'b0;
            t2_cnt_q <= `T2_CNT_RESET;
        end else if (i_clk_en) begin
            div12_q  <= div12_tick ? `DIV12_ZERO : div12_q + 4'h1;
            half_q   <= ~half_q;
            t2_cnt_q <= t2_cnt_d;
        end
    end

    // Pin synchronisers plus one edge-history stage
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            irq0_sync_q <= 3'h0;
            t0p_sync_q  <= 3'h0;
            t2p_sync_q  <= 3'h0;
        end else if (i_clk_en) begin
            irq0_sync_q <= {irq0_sync_q[1:0], i_ext_irq_zero_pin};
            t0p_sync_q  <= {t0p_sync_q[1:0], i_t0_count_pin};
            t2p_sync_q  <= {t2p_sync_q[1:0], i_t2_count_pin};
        end
    end

    // Registered outputs; trades one cycle of latency for clean timing
    always_ff @(posedge i_sys_clk) begin
        if (!i_resetn) begin
            o_sfr_rdata   <= 8'h00;
            o_t0_count_en <= 1'b0;
            o_t0_tick     <= 1'b0;
            o_t0_mode     <= T0_MODE_13BIT;
            o_t1_tick     <= 1'b0;
            o_t2_mode     <= T2_OFF;
            o_t2_overflow <= 1'b0;
            o_adc_trigger <= 1'b0;
        end else if (i_clk_en) begin
            if (i_sfr_rd)
                o_sfr_rdata <= rdata_d;
            o_t0_count_en <= t0_enable;
            o_t0_tick     <= t0_tick_d;
            o_t0_mode     <= t0_mode_d;
            o_t1_tick     <= t1_tick_d;
            o_t2_mode     <= t2_mode_d;
            o_t2_overflow <= t2_wrap;
            o_adc_trigger <= t2_wrap;                                       // RL11
        end
    end

    // Checks
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_resetn);

    a_t0_gate_hold: assert property (i_clk_en && t0_gate && !irq0_level  // RL1
        |=> !o_t0_count_en && !o_t0_tick) else $error("gated timer zero ran");
    a_t0_gate_open: assert property (i_clk_en && i_t0_run && !t0_gate    // RL1
        |=> o_t0_count_en) else $error("ungated timer zero not enabled");
    a_t0_mode_map: assert property (i_clk_en                            // RL2
        |=> o_t0_mode == t0_mode_t'($past(t0_mode_bits)))
        else $error("timer zero mode mismatch");
    a_t0_pin_edge: assert property (i_clk_en && t0_ct && t0_enable      // RL3
        |=> o_t0_tick == $past(t0p_sync_q[2] && !t0p_sync_q[1]))
        else $error("timer zero pin edge mishandled");
    a_t1_div_gap: assert property (i_clk_en && !presc_q[`PRESCALE_T1_DIV] // RL4
        && div12_q != `DIV12_LAST |=> !o_t1_tick) else $error("timer one tick too early");
    a_t1_div_full: assert property (i_clk_en && presc_q[`PRESCALE_T1_DIV] // RL4
        |=> o_t1_tick) else $error("timer one missed undivided tick");
    a_t2_fast_clk: assert property (i_clk_en && t2_run && !t2_ct && !t2_baud // RL5
        && presc_q[`PRESCALE_T2_DIV] && !wr_t2_low && !wr_t2_hi
        |=> t2_cnt_q == $past(t2_cnt_q) + `T2_CNT_ONE) else $error("timer two not at sysclk");
    a_presc_res_zero: assert property (i_clk_en && i_sfr_rd && sel_presc  // RL6
        |=> o_sfr_rdata[2:0] == 3'h0) else $error("reserved prescale bits nonzero");
    a_presc_top_zero: assert property (i_clk_en && i_sfr_rd && sel_presc  // RL7
        |=> o_sfr_rdata[7:6] == 2'h0) else $error("unused prescale bits nonzero");
    a_t2_byte_write: assert property (i_clk_en && wr_t2_low && !wr_t2_hi // RL8
        |=> t2_cnt_q[7:0] == $past(i_sfr_wdata)) else $error("timer two low byte write lost");
    a_t2_div_hold: assert property (i_clk_en && t2_run && !t2_ct && !t2_baud // RL9
        && !presc_q[`PRESCALE_T2_DIV] && !div12_tick && !wr_t2_low && !wr_t2_hi
        |=> $stable(t2_cnt_q)) else $error("timer two counted between prescale ticks");
    a_t2_pin_hold: assert property (i_clk_en && t2_ct && !t2_fall       // RL10
        && !wr_t2_low && !wr_t2_hi |=> $stable(t2_cnt_q)) else $error("timer two counted w/o edge");
    a_adc_trig: assert property (i_clk_en && t2_wrap                    // RL11
        |=> o_adc_trigger ##1 (!o_adc_trigger || $past(t2_wrap) || !$past(i_clk_en)))
        else $error("conversion trigger wrong");
    a_t2_capture: assert property (i_clk_en && t2_run && !t2_baud       // RL12
        && t2_ctl_q[`T2_CTRL_CAP_SEL] |=> o_t2_mode == T2_CAPTURE)
        else $error("capture mode not decoded");
    a_t2_reload: assert property (i_clk_en && t2_run && !t2_baud        // RL13
        && !t2_ctl_q[`T2_CTRL_CAP_SEL] |=> o_t2_mode == T2_RELOAD)
        else $error("reload mode not decoded");
    a_t2_baud_sel: assert property (i_clk_en && t2_run && tx_baud_src_sel // RL14
        && !rx_baud_src_sel |=> o_t2_mode == T2_BAUD_TX)
        else $error("transmit baud mode not decoded");
    a_t2_off_still: assert property (i_clk_en && !t2_run && !wr_t2_low && !wr_t2_hi // RL15
        |=> o_t2_mode == T2_OFF && $stable(t2_cnt_q)) else $error("timer two not off");

    c_t0_gated_tick: cover property (t0_gate && o_t0_tick);
    c_t2_wrap: cover property (o_t2_overflow);
    c_t2_baud_both: cover property (o_t2_mode == T2_BAUD_TXRX);
    c_t2_pin_count: cover property (t2_ct && t2_inc);

endmodule
`default_nettype wire

// ### tb/tb_timer_clock_and_mode_select.sv
// Self-checking testbench for the timer clock and mode select block
`timescale 1ns/1ps
`default_nettype none
`include "timer_cfg_regs.svh"

module tb_timer_clock_and_mode_select;
    import timer_cfg_pkg::*;

    logic       i_sys_clk          = 1'b0;
    logic       i_resetn           = 1'b0;
    logic       i_clk_en           = 1'b1;
    logic [7:0] i_sfr_addr         = 8'h00;
    logic [7:0] i_sfr_wdata        = 8'h00;
    logic       i_sfr_wr           = 1'b0;
    logic       i_sfr_rd           = 1'b0;
    logic       i_t0_run           = 1'b0;
    logic       i_ext_irq_zero_pin = 1'b0;
    logic       i_t0_count_pin     = 1'b1;
    logic       i_t2_count_pin     = 1'b1;
    logic [7:0] o_sfr_rdata;
    logic       o_t0_count_en;
    logic       o_t0_tick;
    t0_mode_t   o_t0_mode;
    logic       o_t1_tick;
    t2_mode_t   o_t2_mode;
    logic       o_t2_overflow;
    logic       o_adc_trigger;
    int         failures           = 0;
    int         check_count        = 0;
    int         n0, n1, n2;
    logic [7:0] t2_wr [7] = '{8'h05, 8'h04, 8'h14, 8'h24, 8'h34, 8'h35, 8'h31};
    t2_mode_t   t2_exp [7] = '{T2_CAPTURE, T2_RELOAD, T2_BAUD_TX, T2_BAUD_RX,
                               T2_BAUD_TXRX, T2_BAUD_TXRX, T2_OFF};

    timer_clock_and_mode_select u_timer_clock_and_mode_select (
        .i_sys_clk          (i_sys_clk),
        .i_resetn           (i_resetn),
        .i_clk_en           (i_clk_en),
        .i_sfr_addr         (i_sfr_addr),
        .i_sfr_wdata        (i_sfr_wdata),
        .i_sfr_wr           (i_sfr_wr),
        .i_sfr_rd           (i_sfr_rd),
        .i_t0_run           (i_t0_run),
        .i_ext_irq_zero_pin (i_ext_irq_zero_pin),
        .i_t0_count_pin     (i_t0_count_pin),
        .i_t2_count_pin     (i_t2_count_pin),
        .o_sfr_rdata        (o_sfr_rdata),
        .o_t0_count_en      (o_t0_count_en),
        .o_t0_tick          (o_t0_tick),
        .o_t0_mode          (o_t0_mode),
        .o_t1_tick          (o_t1_tick),
        .o_t2_mode          (o_t2_mode),
        .o_t2_overflow      (o_t2_overflow),
        .o_adc_trigger      (o_adc_trigger)
    );

    // 100 MHz system clock
    always #5 i_sys_clk = ~i_sys_clk;

    // Verdict and end of run, shared by the tests and the watchdog
    task automatic report_and_stop();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge i_sys_clk);
    endtask

    // One-cycle write strobe; a gap cycle follows so strobes never merge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_sys_clk);
        i_sfr_addr  <= a;
        i_sfr_wdata <= d;
        i_sfr_wr    <= 1'b1;
        @(posedge i_sys_clk);
        i_sfr_wr    <= 1'b0;
    endtask

    // Read data lands on the same edge that takes the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge i_sys_clk);
        i_sfr_addr <= a;
        i_sfr_rd   <= 1'b1;
        @(posedge i_sys_clk);
        i_sfr_rd   <= 1'b0;
        @(negedge i_sys_clk);
        chk(o_sfr_rdata, exp, "read data");
    endtask

    // Counts tick pulses mid-cycle; the converter trigger must mirror overflow
    task automatic count(input int n, output int t0, output int t1, output int t2);
        t0 = 0;
        t1 = 0;
        t2 = 0;
        repeat (n) begin
            @(negedge i_sys_clk);
            if (o_t0_tick === 1'b1) t0++;
            if (o_t1_tick === 1'b1) t1++;
            if (o_t2_overflow === 1'b1) t2++;
            chk(8'(o_adc_trigger), 8'(o_t2_overflow), "adc trigger");
        end
    endtask

    // Both count pins low then high for four cycles each, wide enough to sync
    task automatic pin_fall();
        @(posedge i_sys_clk);
        i_t0_count_pin <= 1'b0;
        i_t2_count_pin <= 1'b0;
        idle(4);
        i_t0_count_pin <= 1'b1;
        i_t2_count_pin <= 1'b1;
        idle(4);
    endtask

    // Stop timer two before loading, so the bytes are not racing increments
    task automatic t2_load(input logic [7:0] hi, input logic [7:0] lo);
        wr(`ADDR_T2_CTRL, 8'h00);
        wr(`ADDR_T2_LOW, lo);
        wr(`ADDR_T2_HIGH, hi);
    endtask

    // Hang guard, far beyond the few hundred cycles the tests need
    initial begin
        #200000;
        failures++;
        $display("[FAIL] %0t watchdog expired", $time);
        report_and_stop();
    end

    initial begin
        idle(4);
        i_resetn <= 1'b1;
        rd(`ADDR_MODE_CFG, 8'h00);
        rd(`ADDR_PRESCALE, 8'h00);
        rd(`ADDR_T2_CTRL, 8'h00);
        wr(8'h00, 8'hff);
        rd(8'h00, 8'h00);
        wr(`ADDR_PRESCALE, 8'hf8);
        rd(`ADDR_PRESCALE, 8'h38);
        // A write while the clock enable is low must not land
        idle(1);
        i_clk_en <= 1'b0;
        wr(`ADDR_MODE_CFG, 8'h0f);
        idle(1);
        i_clk_en <= 1'b1;
        rd(`ADDR_MODE_CFG, 8'h00);
        $display("test registers done");
        for (int i = 0; i < 4; i++) begin
            wr(`ADDR_MODE_CFG, 8'(i));
            idle(2);
            @(negedge i_sys_clk);
            chk(8'(o_t0_mode), 8'(i), "t0 mode");
            rd(`ADDR_MODE_CFG, 8'(i));
        end
        for (int i = 0; i < 7; i++) begin
            wr(`ADDR_T2_CTRL, t2_wr[i]);
            idle(2);
            @(negedge i_sys_clk);
            chk(8'(o_t2_mode), 8'(t2_exp[i]), "t2 mode");
        end
        $display("test mode decode done");
        // Levels are looked at mid-cycle, stimulus goes back on the rising edge
        idle(1);
        i_t0_run <= 1'b1;
        wr(`ADDR_MODE_CFG, 8'h08);
        idle(5);
        @(negedge i_sys_clk);
        chk(8'(o_t0_count_en), 8'h00, "gated, pin low");
        idle(1);
        i_ext_irq_zero_pin <= 1'b1;
        idle(5);
        @(negedge i_sys_clk);
        chk(8'(o_t0_count_en), 8'h01, "gated, pin high");
        idle(1);
        i_ext_irq_zero_pin <= 1'b0;
        wr(`ADDR_MODE_CFG, 8'h00);
        idle(5);
        @(negedge i_sys_clk);
        chk(8'(o_t0_count_en), 8'h01, "ungated, pin low");
        idle(1);
        i_t0_run <= 1'b0;
        idle(3);
        @(negedge i_sys_clk);
        chk(8'(o_t0_count_en), 8'h00, "run off");
        $display("test gate done");
        idle(1);
        i_t0_run <= 1'b1;
        wr(`ADDR_PRESCALE, 8'h08);
        idle(3);
        count(24, n0, n1, n2);
        chk(8'(n0), 8'd24, "t0 undivided");
        chk(8'(n1), 8'd2, "t1 divided");
        wr(`ADDR_PRESCALE, 8'h10);
        idle(3);
        count(24, n0, n1, n2);
        chk(8'(n0), 8'd2, "t0 divided");
        chk(8'(n1), 8'd24, "t1 undivided");
        $display("test timebases done");
        t2_load(8'hff, 8'hfe);
        rd(`ADDR_T2_LOW, 8'hfe);
        rd(`ADDR_T2_HIGH, 8'hff);
        wr(`ADDR_MODE_CFG, 8'h04);
        wr(`ADDR_T2_CTRL, 8'h06);
        fork
            count(40, n0, n1, n2);
            begin
                pin_fall();
                pin_fall();
            end
        join
        chk(8'(n0), 8'd2, "t0 pin falls");
        chk(8'(n2), 8'd1, "t2 pin wrap");
        rd(`ADDR_T2_LOW, 8'h00);
        rd(`ADDR_T2_HIGH, 8'h00);
        $display("test counters done");
        t2_load(8'hff, 8'hec);
        wr(`ADDR_PRESCALE, 8'h20);
        wr(`ADDR_T2_CTRL, 8'h04);
        count(30, n0, n1, n2);
        chk(8'(n2), 8'd1, "t2 undivided");
        t2_load(8'hff, 8'hfd);
        wr(`ADDR_PRESCALE, 8'h00);
        wr(`ADDR_T2_CTRL, 8'h05);
        count(20, n0, n1, n2);
        chk(8'(n2), 8'd0, "t2 div12 early");
        count(30, n0, n1, n2);
        chk(8'(n2), 8'd1, "t2 div12 late");
        t2_load(8'hff, 8'hff);
        count(30, n0, n1, n2);
        chk(8'(n2), 8'd0, "t2 stopped");
        t2_load(8'hff, 8'hf6);
        wr(`ADDR_PRESCALE, 8'h20);
        wr(`ADDR_T2_CTRL, 8'h14);
        count(14, n0, n1, n2);
        chk(8'(n2), 8'd0, "baud half rate early");
        count(14, n0, n1, n2);
        chk(8'(n2), 8'd1, "baud half rate late");
        $display("test timer two clocks done");
        report_and_stop();
    end
endmodule
`default_nettype wire
